// file: hw/dbr_block_ram.sv
// Dual-port block memory with aspect ratios, read-during-write modes and FIFO mode
`default_nettype none
// Operation
// - 18 Kbit array behind two independent ports
// - Each port picks its own aspect ratio
// - Write completes on one clock edge
// - Read completes on one clock edge; a cascade read takes two, from either block
// - Output holds until same port operates
// - Port inputs captured at the clock edge
// - Write strobe selects read or read-during-write
// - Write shows new, old or unchanged data
// - Pipeline register adds one cycle latency
// - Two blocks cascade into 32Kx1
// - Byte write enables on 18/36 ports
// - FIFO sequences addresses, four fixed shapes
// - FIFO transfers gated by write/read enables
// - FIFO full and empty flags, glitch free
// - Programmable near-full and near-empty flags
// - Contents loadable or clearable before use
// - Disabled port writes nothing, holds output
// - Per-port mode, default new data
// - Hold mode unavailable in cascade
module dbr_block_ram import dbr_pkg::*; (
	// Clock and reset
	input wire logic clk_i,
	input wire logic rst_i,
	// Wishbone slave
	input wire logic wb_cyc_i,
	input wire logic wb_stb_i,
	input wire logic wb_we_i,
	input wire logic [WB_AW-1:0] wb_adr_i,
	input wire logic [3:0] wb_sel_i,
	input wire logic [31:0] wb_dat_i,
	output logic [31:0] wb_dat_o,
	output logic wb_ack_o,
	// Memory ports, index 0 is port A
	input wire dbr_req_t [1:0] port_i,
	output logic [1:0][WORD_W-1:0] dout_o,
	// Cascade link to the neighbour block
	input wire logic [1:0] cascade_in_i,
	output logic [1:0] cascade_out_o,
	// FIFO flags
	output logic fifo_full_o,
	output logic fifo_empty_o,
	output logic near_full_flag_o,
	output logic near_empty_flag_o
);
	function automatic logic [IDX_W-1:0] word_idx(input logic [2:0] c, input logic [14:0] a);
		unique case (c)
			W2: return a[12:4];
			W4: return a[11:3];
			W9: return a[10:2];
			W18: return a[9:1];
			W36: return a[8:0];
			default: return a[13:5];
		endcase
	endfunction

	// Narrow ratios use the 8 data bits of each 9-bit lane; the ninth bit is parity
	function automatic logic [71:0] place(input logic [2:0] c, input logic [14:0] a,
			input logic [3:0] be, input logic [35:0] d);
		logic [35:0] m;
		logic [35:0] v;
		int lane;
		int off;
		int rel;
		int base;
		int e;
		m = '0;
		v = '0;
		base = (c == W2) ? int'(a[3:0]) * 2 : (c == W4) ? int'(a[2:0]) * 4 : int'(a[4:0]);
		e = (c == W2) ? 2 : (c == W4) ? 4 : 1;
		for (int b = 0; b < 36; b++) begin
			lane = b / 9;
			off = b % 9;
			rel = lane * 8 + off - base;
			case (c)
				W9: if (lane == int'(a[1:0])) begin
					m[b] = 1'b1;
					v[b] = d[off];
				end
				W18: if (lane / 2 == int'(a[0])) begin
					m[b] = be[lane % 2];
					v[b] = d[(lane % 2) * 9 + off];
				end
				W36: begin
					m[b] = be[lane];
					v[b] = d[b];
				end
				default: if (off < 8 && rel >= 0 && rel < e) begin
					m[b] = 1'b1;
					v[b] = d[rel];
				end
			endcase
		end
		return {m, v};
	endfunction

	function automatic logic [35:0] extract(input logic [2:0] c, input logic [14:0] a,
			input logic [35:0] w);
		logic [35:0] o;
		int lane;
		int off;
		int rel;
		int base;
		int e;
		o = '0;
		base = (c == W2) ? int'(a[3:0]) * 2 : (c == W4) ? int'(a[2:0]) * 4 : int'(a[4:0]);
		e = (c == W2) ? 2 : (c == W4) ? 4 : 1;
		for (int b = 0; b < 36; b++) begin
			lane = b / 9;
			off = b % 9;
			rel = lane * 8 + off - base;
			case (c)
				W9: if (lane == int'(a[1:0])) o[off] = w[b];
				W18: if (lane / 2 == int'(a[0])) o[(lane % 2) * 9 + off] = w[b];
				W36: o[b] = w[b];
				default: if (off < 8 && rel >= 0 && rel < e) o[rel] = w[b];
			endcase
		end
		return o;
	endfunction

	function automatic logic [31:0] merge32(input logic [31:0] o, input logic [31:0] n,
			input logic [3:0] s);
		logic [31:0] r;
		r = o;
		for (int i = 0; i < 4; i++) if (s[i]) r[i*8 +: 8] = n[i*8 +: 8];
		return r;
	endfunction

	logic [WORD_W-1:0] mem [WORDS];
	dbr_cfg_t [1:0] cfg;
	logic fifo_en;
	logic casc_upper;
	logic [1:0] fifo_code;
	logic [CNT_W-1:0] nf_thr;
	logic [CNT_W-1:0] ne_thr;
	logic [IDX_W-1:0] load_idx;
	logic [3:0] load_hi;
	logic clr_busy;
	logic [IDX_W-1:0] clr_idx;
	logic [11:0] wptr;
	logic [11:0] rptr;
	logic [CNT_W-1:0] count;
	logic [1:0][WORD_W-1:0] lat;
	logic [1:0] cpend;
	logic [1:0] cself;

	logic [2:0] code [2];
	logic [14:0] addr [2];
	logic [1:0] op;
	logic [1:0] wr;
	logic [1:0] hold;
	logic [1:0] act;
	logic [IDX_W-1:0] widx [2];
	logic [71:0] plc [2];
	logic [WORD_W-1:0] oldw [2];
	logic [WORD_W-1:0] neww [2];
	logic [WORD_W-1:0] rd_val [2];
	logic push;
	logic pop;
	logic same_word;
	logic [CNT_W-1:0] depth;
	logic [11:0] pmask;
	logic [CNT_W-1:0] next_count;
	logic wb_req;
	logic wb_wr;

	assign wb_req = wb_cyc_i && wb_stb_i && !wb_ack_o;
	// Writes land at the edge where the master sees ack high, never earlier
	assign wb_wr = wb_cyc_i && wb_stb_i && wb_ack_o && wb_we_i;

	always_comb begin
		depth = FIFO_DEPTH_MAX >> fifo_code;
		pmask = 12'(depth - 13'h0001);
		push = fifo_en && port_i[0].en && port_i[0].write_strobe && count != depth;
		pop = fifo_en && port_i[1].en && count != '0;
		next_count = count + CNT_W'(push) - CNT_W'(pop);
		for (int p = 0; p < 2; p++) begin
			code[p] = fifo_en ? (W4 + 3'(fifo_code)) : cfg[p].width;
			addr[p] = fifo_en ? {3'h0, (p == 0) ? wptr : rptr} : port_i[p].addr;
			act[p] = (code[p] != WCASC) || (addr[p][14] == casc_upper);
			op[p] = fifo_en ? ((p == 0) ? push : pop) : port_i[p].en;
			wr[p] = op[p] && act[p] && (fifo_en ? (p == 0) : port_i[p].write_strobe);
			widx[p] = word_idx(code[p], addr[p]);
			plc[p] = place(code[p], addr[p], fifo_en ? 4'hF : port_i[p].be,
				port_i[p].write_data_bus);
			oldw[p] = mem[widx[p]];
			hold[p] = wr[p] && cfg[p].rdw == RDW_HOLD && code[p] != WCASC;
		end
		same_word = wr[0] && widx[0] == widx[1];
		neww[0] = (oldw[0] & ~plc[0][71:36]) | (plc[0][35:0] & plc[0][71:36]);
		// Port B merges over port A so distinct lanes of one word both land
		neww[1] = ((same_word ? neww[0] : oldw[1]) & ~plc[1][71:36])
			| (plc[1][35:0] & plc[1][71:36]);
		for (int p = 0; p < 2; p++) begin
			rd_val[p] = extract(code[p], addr[p],
				(wr[p] && cfg[p].rdw != RDW_OLD) ? neww[p] : oldw[p]);
		end
	end

	// Array writes; on one word port B lands last, equal data is the user's duty
	always_ff @(posedge clk_i) begin
		if (clr_busy) begin
			mem[clr_idx] <= '0;
		end else if (wb_wr && wb_adr_i == OFS_LOAD_DATA) begin
			mem[load_idx] <= {load_hi, wb_dat_i};
		end else begin
			if (wr[0] && !(wr[1] && widx[1] == widx[0])) mem[widx[0]] <= neww[0];
			if (wr[1]) mem[widx[1]] <= neww[1];
		end
	end

	// Output latches, pipeline and cascade selection
	always_ff @(posedge clk_i) begin
		if (rst_i) begin
			lat <= '0;
			dout_o <= '0;
			cpend <= '0;
			cself <= '0;
			cascade_out_o <= '0;
		end else begin
			for (int p = 0; p < 2; p++) begin
				cpend[p] <= op[p] && code[p] == WCASC;
				cself[p] <= act[p];
				if (op[p] && !hold[p]) lat[p] <= rd_val[p];
				if (op[p] && code[p] == WCASC) cascade_out_o[p] <= rd_val[p][0];
				if (cpend[p]) begin
					dout_o[p] <= {35'h0, cself[p] ? lat[p][0] : cascade_in_i[p]};
				end else if (cfg[p].pipe) begin
					dout_o[p] <= lat[p];
				end else if (op[p] && !hold[p]) begin
					dout_o[p] <= rd_val[p];
				end
			end
		end
	end

	// FIFO pointers and flags, all registered so flags cannot glitch
	always_ff @(posedge clk_i) begin
		if (rst_i || !fifo_en) begin
			wptr <= '0;
			rptr <= '0;
			count <= '0;
			fifo_full_o <= 1'b0;
			fifo_empty_o <= 1'b1;
			near_full_flag_o <= 1'b0;
			near_empty_flag_o <= 1'b1;
		end else begin
			if (push) wptr <= (wptr + 12'h001) & pmask;
			if (pop) rptr <= (rptr + 12'h001) & pmask;
			count <= next_count;
			fifo_full_o <= next_count == depth;
			fifo_empty_o <= next_count == '0;
			near_full_flag_o <= next_count >= nf_thr;
			near_empty_flag_o <= next_count <= ne_thr;
		end
	end

	// Contents clear sweep
	always_ff @(posedge clk_i) begin
		if (rst_i) begin
			clr_busy <= 1'b0;
			clr_idx <= '0;
		end else if (clr_busy) begin
			clr_idx <= clr_idx + 9'h001;
			clr_busy <= clr_idx != CLR_LAST;
		end else if (wb_wr && wb_adr_i == OFS_CLEAR && wb_sel_i[0] && wb_dat_i[0]) begin
			clr_busy <= 1'b1;
			clr_idx <= '0;
		end
	end

	// Register writes
	always_ff @(posedge clk_i) begin
		if (rst_i) begin
			cfg <= {CFG_RST, CFG_RST};
			{fifo_code, casc_upper, fifo_en} <= MODE_RST;
			nf_thr <= NF_THR_RST;
			ne_thr <= NE_THR_RST;
			load_idx <= '0;
			load_hi <= '0;
		end else if (wb_wr) begin
			unique case (wb_adr_i)
				OFS_CFG_A: cfg[0] <= 6'(merge32(32'(cfg[0]), wb_dat_i, wb_sel_i));
				OFS_CFG_B: cfg[1] <= 6'(merge32(32'(cfg[1]), wb_dat_i, wb_sel_i));
				OFS_MODE: {fifo_code, casc_upper, fifo_en} <= 4'(merge32(
					{28'h0, fifo_code, casc_upper, fifo_en}, wb_dat_i, wb_sel_i));
				OFS_NF_THR: nf_thr <= 13'(merge32({19'h0, nf_thr}, wb_dat_i, wb_sel_i));
				OFS_NE_THR: ne_thr <= 13'(merge32({19'h0, ne_thr}, wb_dat_i, wb_sel_i));
				OFS_LOAD_ADDR: load_idx <= 9'(merge32({23'h0, load_idx}, wb_dat_i, wb_sel_i));
				OFS_LOAD_HI: load_hi <= 4'(merge32({28'h0, load_hi}, wb_dat_i, wb_sel_i));
				OFS_LOAD_DATA: load_idx <= load_idx + 9'h001;
				default: ;
			endcase
		end
	end

	// Register reads and acknowledge; unmapped addresses answer zero
	always_ff @(posedge clk_i) begin
		if (rst_i) begin
			wb_ack_o <= 1'b0;
			wb_dat_o <= '0;
		end else begin
			wb_ack_o <= wb_req;
			if (wb_req && !wb_we_i) begin
				unique case (wb_adr_i)
					OFS_CFG_A: wb_dat_o <= {26'h0, cfg[0]};
					OFS_CFG_B: wb_dat_o <= {26'h0, cfg[1]};
					OFS_MODE: wb_dat_o <= {28'h0, fifo_code, casc_upper, fifo_en};
					OFS_NF_THR: wb_dat_o <= {19'h0, nf_thr};
					OFS_NE_THR: wb_dat_o <= {19'h0, ne_thr};
					OFS_STATUS: wb_dat_o <= {3'h0, count, 11'h0, clr_busy, near_full_flag_o,
						near_empty_flag_o, fifo_full_o, fifo_empty_o};
					OFS_LOAD_ADDR: wb_dat_o <= {23'h0, load_idx};
					OFS_LOAD_HI: wb_dat_o <= {28'h0, load_hi};
					default: wb_dat_o <= '0;
				endcase
			end
		end
	end

	sequence s_plain_op(int p);
		op[p] && !hold[p] && code[p] != WCASC;
	endsequence

	for (genvar p = 0; p < 2; p++) begin : g_chk
		a_read_latency:
		assert property (@(posedge clk_i) disable iff (rst_i)
			s_plain_op(p) ##0 !cfg[p].pipe |=> dout_o[p] == $past(rd_val[p]))
			else $error("port output missed one-edge read");
		a_pipe_extra:
		assert property (@(posedge clk_i) disable iff (rst_i)
			s_plain_op(p) ##0 cfg[p].pipe ##1 cfg[p].pipe && !op[p]
			|=> dout_o[p] == $past(lat[p]) && lat[p] == $past(rd_val[p], 2))
			else $error("pipelined read not one cycle later");
		a_idle_hold:
		assert property (@(posedge clk_i) disable iff (rst_i)
			!op[p] && !cpend[p] && !cfg[p].pipe |=> $stable(dout_o[p]))
			else $error("idle port output changed");
		a_nochange_hold:
		assert property (@(posedge clk_i) disable iff (rst_i)
			hold[p] && !cfg[p].pipe && !cpend[p] |=> $stable(dout_o[p]) && $stable(lat[p]))
			else $error("hold mode output changed on write");
	end

	a_byte_lane:
	assert property (@(posedge clk_i) disable iff (rst_i)
		wr[0] && !wr[1] && !clr_busy && !wb_wr && code[0] == W36 && !port_i[0].be[0]
		|=> mem[$past(widx[0])][8:0] == $past(oldw[0][8:0]))
		else $error("disabled byte lane was written");
	a_fifo_full:
	assert property (@(posedge clk_i) disable iff (rst_i)
		fifo_en && push && !pop && count == depth - 13'h0001 ##1 fifo_en
		|-> fifo_full_o && !near_empty_flag_o)
		else $error("full flag late");
	a_fifo_empty:
	assert property (@(posedge clk_i) disable iff (rst_i)
		fifo_en && pop && !push && count == 13'h0001 ##1 fifo_en |-> fifo_empty_o)
		else $error("empty flag late");
	a_near_flags:
	assert property (@(posedge clk_i) disable iff (rst_i)
		fifo_en |-> near_full_flag_o == (count >= nf_thr) && near_empty_flag_o == (count <= ne_thr))
		else $error("near flag disagrees with threshold");
	a_clear_end:
	assert property (@(posedge clk_i) disable iff (rst_i)
		clr_busy && clr_idx == CLR_LAST |=> !clr_busy && mem[CLR_LAST] == '0)
		else $error("clear sweep did not end at last word");
	a_wb_ack:
	assert property (@(posedge clk_i) disable iff (rst_i)
		wb_req |=> wb_ack_o ##1 !wb_ack_o)
		else $error("bus acknowledge not a single cycle");
endmodule // dbr_block_ram
`default_nettype wire

// file: common/dbr_pkg.sv
// Constants, configuration fields and port carriers of the dual-port block memory
`default_nettype none
package dbr_pkg;
	localparam int WORDS = 512;
	localparam int WORD_W = 36;
	localparam int ADDR_W = 15;
	localparam int IDX_W = 9;
	localparam int CNT_W = 13;
	localparam int WB_AW = 8;

	// Port aspect-ratio codes
	localparam logic [2:0] W1 = 3'h0;
	localparam logic [2:0] W2 = 3'h1;
	localparam logic [2:0] W4 = 3'h2;
	localparam logic [2:0] W9 = 3'h3;
	localparam logic [2:0] W18 = 3'h4;
	localparam logic [2:0] W36 = 3'h5;
	localparam logic [2:0] WCASC = 3'h6;

	// Read-during-write output modes
	localparam logic [1:0] RDW_NEW = 2'h0;
	localparam logic [1:0] RDW_OLD = 2'h1;
	localparam logic [1:0] RDW_HOLD = 2'h2;

	// Register byte offsets
	localparam logic [7:0] OFS_CFG_A = 8'h00;
	localparam logic [7:0] OFS_CFG_B = 8'h04;
	localparam logic [7:0] OFS_MODE = 8'h08;
	localparam logic [7:0] OFS_NF_THR = 8'h0C;
	localparam logic [7:0] OFS_NE_THR = 8'h10;
	localparam logic [7:0] OFS_STATUS = 8'h14;
	localparam logic [7:0] OFS_LOAD_ADDR = 8'h18;
	localparam logic [7:0] OFS_LOAD_HI = 8'h1C;
	localparam logic [7:0] OFS_LOAD_DATA = 8'h20;
	localparam logic [7:0] OFS_CLEAR = 8'h24;

	// Values after reset, FIFO depth limit and last clear index
	localparam logic [5:0] CFG_RST = 6'h05;
	localparam logic [3:0] MODE_RST = 4'h0;
	localparam logic [12:0] NF_THR_RST = 13'h01F0;
	localparam logic [12:0] NE_THR_RST = 13'h0010;
	localparam logic [12:0] FIFO_DEPTH_MAX = 13'h1000;
	localparam logic [8:0] CLR_LAST = 9'h1FF;

	typedef struct packed {
		logic pipe;
		logic [1:0] rdw;
		logic [2:0] width;
	} dbr_cfg_t;

	typedef struct packed {
		logic en;
		logic write_strobe;
		logic [3:0] be;
		logic [ADDR_W-1:0] addr;
		logic [WORD_W-1:0] write_data_bus;
	} dbr_req_t;
endpackage
`default_nettype wire

// file: tb/dbr_fabric.sv
// User fabric model that drives both memory ports
`default_nettype none
module dbr_fabric import dbr_pkg::*; (
	// Clock
	input wire logic clk_i,
	// Port requests
	output var dbr_req_t [1:0] port_o
);
	timeunit 1ns;
	timeprecision 1ps;

	initial port_o = '0;

	// Callers never aim both ports at one word in the same cycle
	task automatic op(input int p, input logic we, input logic [3:0] be,
		input logic [14:0] a, input logic [35:0] d);
		@(posedge clk_i);
		port_o[p] <= '{en: 1'b1, write_strobe: we, be: be, addr: a, write_data_bus: d};
		@(posedge clk_i);
		// Idle lines carry the inverse so a stale value cannot pass for a hold
		port_o[p] <= '{en: 1'b0, write_strobe: ~we, be: ~be, addr: ~a, write_data_bus: ~d};
	endtask
endmodule // dbr_fabric
`default_nettype wire

// file: tb/testbench.sv
// Self-checking bench for the dual-port block memory
`default_nettype none
module testbench import dbr_pkg::*;;
	timeunit 1ns;
	timeprecision 1ps;

	logic clk_i = 1'b0;
	logic rst_i = 1'b1;
	logic wb_cyc_i = 1'b0;
	logic wb_stb_i = 1'b0;
	logic wb_we_i = 1'b0;
	logic [7:0] wb_adr_i = 8'h00;
	logic [3:0] wb_sel_i = 4'h0;
	logic [31:0] wb_dat_i = 32'h0;
	logic [31:0] wb_dat_o;
	logic wb_ack_o;
	dbr_req_t [1:0] port_i;
	logic [1:0][35:0] dout_o;
	logic full, empty, nf, ne;
	logic [31:0] rd;
	logic [1:0] casc_o;
	int bad_count = 0;
	int comparisons = 0;
	logic [7:0] offs [6] = '{OFS_CFG_A, OFS_CFG_B, OFS_MODE, OFS_NF_THR, OFS_NE_THR, 8'hFC};
	logic [31:0] rst_v [6] = '{32'(CFG_RST), 32'(CFG_RST), 32'(MODE_RST), 32'(NF_THR_RST),
		32'(NE_THR_RST), 32'h0};

	always #2 clk_i = ~clk_i;

	dbr_block_ram dut_u (.clk_i(clk_i), .rst_i(rst_i), .wb_cyc_i(wb_cyc_i),
		.wb_stb_i(wb_stb_i), .wb_we_i(wb_we_i), .wb_adr_i(wb_adr_i), .wb_sel_i(wb_sel_i),
		.wb_dat_i(wb_dat_i), .wb_dat_o(wb_dat_o), .wb_ack_o(wb_ack_o), .port_i(port_i),
		.dout_o(dout_o), .cascade_in_i(2'h0), .cascade_out_o(casc_o), .fifo_full_o(full),
		.fifo_empty_o(empty), .near_full_flag_o(nf), .near_empty_flag_o(ne));
	dbr_fabric fab_u (.clk_i(clk_i), .port_o(port_i));

	task automatic check(input logic [35:0] seen, input logic [35:0] exp);
		comparisons++;
		if (seen !== exp) begin
			bad_count++;
			$display("CHECK FAILED t=%0t seen=%h exp=%h", $time, seen, exp);
		end
	endtask

	task automatic wb(input logic we, input logic [7:0] a, input logic [31:0] d);
		int n;
		@(posedge clk_i);
		wb_cyc_i <= 1'b1;
		wb_stb_i <= 1'b1;
		wb_we_i <= we;
		wb_adr_i <= a;
		wb_sel_i <= 4'hF;
		wb_dat_i <= d;
		n = 0;
		do begin
			@(posedge clk_i);
			n++;
		end while (wb_ack_o !== 1'b1 && n < 50);
		if (n >= 50) bad_count++;
		rd = wb_dat_o;
		wb_cyc_i <= 1'b0;
		wb_stb_i <= 1'b0;
	endtask

	task automatic op(input int p, input logic we, input logic [3:0] be,
		input logic [14:0] a, input logic [35:0] d);
		fab_u.op(p, we, be, a, d);
		#1;
	endtask

	task automatic print_verdict();
		$display("Comparisons %0d, mismatches %0d", comparisons, bad_count);
		if (bad_count == 0 && comparisons > 0)
			$display("Testbench passed");
		else
			$display("Testbench failed");
		$finish;
	endtask

	initial begin
		#100000;
		bad_count++;
		print_verdict();
	end

	initial begin
		repeat (5) @(posedge clk_i);
		rst_i <= 1'b0;
		#1;
		check({dout_o[0], empty, full, ne, nf}, {36'h0, 4'hA});
		for (int i = 0; i < 6; i++) begin
			wb(1'b0, offs[i], 32'h0);
			check(rd, rst_v[i]);
		end
		wb(1'b1, OFS_CLEAR, 32'h1);
		rd = '1;
		for (int i = 0; i < 400 && rd[4] !== 1'b0; i++) wb(1'b0, OFS_STATUS, 32'h0);
		check(rd[4], 1'b0);
		op(0, 1'b1, 4'hF, 15'h7, 36'h9_1234_5678);
		check(dout_o[0], 36'h9_1234_5678);
		op(1, 1'b0, 4'hF, 15'h7, 36'h0);
		check(dout_o[1], 36'h9_1234_5678);
		repeat (3) @(posedge clk_i);
		#1;
		check(dout_o[1], 36'h9_1234_5678);
		op(0, 1'b0, 4'hF, 15'h7, 36'h0);
		check(dout_o[0], 36'h9_1234_5678);
		for (int m = 0; m < 3; m++) begin
			wb(1'b1, OFS_CFG_A, {26'h0, 1'b0, 2'(m), W36});
			op(0, 1'b1, 4'hF, 15'(20 + m), 36'hA_0000_0000 + m);
			op(0, 1'b0, 4'hF, 15'h1E, 36'h0);
			op(0, 1'b1, 4'hF, 15'(20 + m), 36'h5_FFFF_FFF0);
			check(dout_o[0], m == 0 ? 36'h5_FFFF_FFF0 : m == 1 ? 36'hA_0000_0000 + m : 36'h0);
		end
		wb(1'b1, OFS_CFG_A, 32'h25);
		op(0, 1'b0, 4'hF, 15'h1E, 36'h0);
		fab_u.op(0, 1'b0, 4'hF, 15'h7, 36'h0);
		#1;
		check(dout_o[0], 36'h0);
		@(posedge clk_i);
		#1;
		check(dout_o[0], 36'h9_1234_5678);
		wb(1'b1, OFS_CFG_A, 32'(CFG_RST));
		op(0, 1'b1, 4'hF, 15'h32, 36'hF_FFFF_FFFF);
		op(0, 1'b1, 4'h5, 15'h32, 36'h0);
		op(1, 1'b0, 4'hF, 15'h32, 36'h0);
		check(dout_o[1], 36'hF_F803_FE00);
		op(0, 1'b1, 4'hE, 15'h32, 36'hF_FFFF_FFFF);
		op(1, 1'b0, 4'hF, 15'h32, 36'h0);
		check(dout_o[1], 36'hF_FFFF_FE00);
		wb(1'b1, OFS_LOAD_ADDR, 32'h3C);
		wb(1'b1, OFS_LOAD_HI, 32'hC);
		wb(1'b1, OFS_LOAD_DATA, 32'h1357_9BDF);
		wb(1'b1, OFS_LOAD_DATA, 32'h2468_ACE0);
		op(1, 1'b0, 4'hF, 15'h3C, 36'h0);
		check(dout_o[1], 36'hC_1357_9BDF);
		op(1, 1'b0, 4'hF, 15'h3D, 36'h0);
		check(dout_o[1], 36'hC_2468_ACE0);
		wb(1'b1, OFS_CFG_A, 32'(W1));
		wb(1'b1, OFS_CFG_B, 32'(W1));
		op(0, 1'b1, 4'hF, 15'h3, 36'h1);
		op(1, 1'b0, 4'hF, 15'h3, 36'h0);
		check(dout_o[1][0], 1'b1);
		op(1, 1'b0, 4'hF, 15'h2, 36'h0);
		check(dout_o[1][0], 1'b0);
		wb(1'b1, OFS_CFG_A, 32'(WCASC));
		op(0, 1'b1, 4'hF, 15'h5, 36'h1);
		check(casc_o[0], 1'b1);
		@(posedge clk_i);
		#1;
		check(dout_o[0], 36'h1);
		op(0, 1'b0, 4'hF, 15'h4005, 36'h0);
		@(posedge clk_i);
		#1;
		check(dout_o[0], 36'h0);
		wb(1'b1, OFS_CFG_A, 32'(CFG_RST));
		wb(1'b1, OFS_CFG_B, 32'(CFG_RST));
		wb(1'b1, OFS_NE_THR, 32'h2);
		wb(1'b1, OFS_MODE, 32'hD);
		#1;
		check(empty, 1'b1);
		for (int i = 0; i < 3; i++) op(0, 1'b1, 4'hF, 15'h0, 36'h5_0000_0000 + i);
		check({empty, ne}, 2'b00);
		wb(1'b0, OFS_STATUS, 32'h0);
		check(rd[28:16], 13'h3);
		for (int i = 0; i < 3; i++) begin
			op(1, 1'b0, 4'hF, 15'h0, 36'h0);
			check(dout_o[1], 36'h5_0000_0000 + i);
		end
		check({empty, ne}, 2'b11);
		for (int i = 0; i < 512; i++) begin
			op(0, 1'b1, 4'hF, 15'h0, 36'h100 + i);
			if (i == 494) check(nf, 1'b0);
		end
		check({full, nf}, 2'b11);
		op(0, 1'b1, 4'hF, 15'h0, 36'h0);
		wb(1'b0, OFS_STATUS, 32'h0);
		check(rd[28:16], 13'h200);
		op(1, 1'b0, 4'hF, 15'h0, 36'h0);
		check({dout_o[1], full}, {36'h100, 1'b0});
		print_verdict();
	end
endmodule // testbench
`default_nettype wire
